// *** core/sph_pkg.sv ***
package sph_pkg;

  // packet framing
  localparam logic [7:0] SPH_TYPE_REQ   = 8'h50;
  localparam logic [7:0] SPH_TYPE_RESP  = 8'h55;
  localparam int         SPH_HDR_BYTES  = 8;
  localparam logic [3:0] SPH_POS_TYPE   = 4'h0;
  localparam logic [3:0] SPH_POS_CODE   = 4'h1;
  localparam logic [3:0] SPH_POS_LEN    = 4'h4;
  localparam logic [3:0] SPH_POS_RESULT = 4'h8;
  localparam logic [3:0] SPH_RESP_BASE  = 4'h9;
  localparam logic [3:0] SPH_HDR_LAST   = 4'h7;

  // command codes
  localparam logic [7:0] SPH_FLASH_WRITE_CMD      = 8'h11;
  localparam logic [7:0] SPH_OTP_WRITE_CMD        = 8'h12;
  localparam logic [7:0] SPH_OTP_READ_CMD         = 8'h13;
  localparam logic [7:0] SPH_DEBUG_AUTH_SET_CMD   = 8'h14;
  localparam logic [7:0] SPH_DEBUG_AUTH_GET_CMD   = 8'h15;
  localparam logic [7:0] SPH_DEBUG_AUTH_KEY_SET_CMD = 8'h16;
  localparam logic [7:0] SPH_SERIAL_BOOT_DISABLE_CMD = 8'h17;
  localparam logic [7:0] SPH_SERIAL_BOOT_QUERY_CMD   = 8'h18;
  localparam logic [7:0] SPH_CHIP_SERIAL_READ_CMD    = 8'h21;
  localparam logic [7:0] SPH_SERIAL_BOOT_AUTH_SET_CMD = 8'h22;
  localparam logic [7:0] SPH_SERIAL_BOOT_AUTH_GET_CMD = 8'h23;
  localparam logic [7:0] SPH_SERIAL_BOOT_KEY_SET_CMD  = 8'h24;

  // flash write payload: 4 address bytes, then data
  localparam logic [31:0] SPH_FLASH_ADDR_BYTES = 32'h0000_0004;

  // result codes
  localparam logic [7:0] SPH_RES_OK       = 8'h00;
  localparam logic [7:0] SPH_RES_BAD_SUM  = 8'h01;
  localparam logic [7:0] SPH_RES_BAD_TYPE = 8'h02;
  localparam logic [7:0] SPH_RES_BAD_CODE = 8'h03;
  localparam logic [7:0] SPH_RES_BAD_LEN  = 8'h04;

  // payload buffer
  localparam int          SPH_BUF_AW    = 6;
  localparam logic [31:0] SPH_BUF_BYTES = 32'h0000_0040;

  // reset values
  localparam logic [7:0]  SPH_BYTE_RST = 8'h00;
  localparam logic [31:0] SPH_WORD_RST = 32'h0000_0000;
  localparam logic [3:0]  SPH_IDX_RST  = 4'h0;

  // one byte of a stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sph_byte_t;

  // action request towards the setup engine
  typedef struct packed {
    logic        start;
    logic [7:0]  code;
    logic [31:0] len;
    logic [31:0] addr;
  } sph_act_req_t;

  // answer from the setup engine
  typedef struct packed {
    logic        done;
    logic [7:0]  result;
    logic [2:0]  extra_len;
    logic [31:0] extra_data;
  } sph_act_ans_t;

endpackage

// *** core/sph_resp_tx.sv ***
`timescale 1ns/1ps
module sph_resp_tx (
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  input  wire logic             start_in,
  input  wire logic [7:0]       code_in,
  input  wire logic [7:0]       result_in,
  input  wire logic [2:0]       extra_len_in,
  input  wire logic [31:0]      extra_data_in,
  input  wire logic             tx_ready_in,
  output sph_pkg::sph_byte_t    tx_out,
  output logic                  done_out
);
  import sph_pkg::*;

  typedef struct packed {
    logic        busy;
    logic [3:0]  idx;
    logic [7:0]  sum;
    logic [7:0]  code;
    logic [7:0]  result;
    logic [2:0]  xlen;
    logic [31:0] xdata;
    sph_byte_t   tx;
    logic        done;
  } sph_tx_state_t;

  sph_tx_state_t st, next_st;

  // byte of the response at a given position, checksum excluded
  function automatic logic [7:0] byte_at(input logic [3:0] i,
                                         input logic [7:0] c,
                                         input logic [7:0] r,
                                         input logic [2:0] xl,
                                         input logic [31:0] xd);
    logic [3:0] k;
    k = i - SPH_RESP_BASE;
    if (i == SPH_POS_TYPE)        byte_at = SPH_TYPE_RESP;
    else if (i == SPH_POS_CODE)   byte_at = c;
    else if (i == SPH_POS_LEN)    byte_at = 8'h01 + {5'h00, xl};
    else if (i == SPH_POS_RESULT) byte_at = r;
    else if (i > SPH_POS_RESULT)  byte_at = xd[{k[1:0], 3'h0} +: 8];
    else                          byte_at = SPH_BYTE_RST; // filler
  endfunction

  logic [3:0] last_idx;
  assign last_idx = SPH_RESP_BASE + {1'b0, st.xlen};

  // =====================================================
  // serialiser
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (!st.busy && start_in) begin
      next_st.busy     = 1'b1;
      next_st.idx      = SPH_IDX_RST;
      next_st.sum      = SPH_BYTE_RST;
      next_st.code     = code_in;
      next_st.result   = result_in;
      next_st.xlen     = extra_len_in;
      next_st.xdata    = extra_data_in;
      next_st.tx.valid = 1'b1;
      next_st.tx.data  = SPH_TYPE_RESP;
    end else if (st.busy && st.tx.valid && tx_ready_in) begin
      next_st.sum = st.sum + st.tx.data;
      next_st.idx = st.idx + 4'h1;
      if (st.idx == last_idx) begin
        next_st.busy     = 1'b0;
        next_st.tx.valid = 1'b0;
        next_st.done     = 1'b1;
      end else if (st.idx + 4'h1 == last_idx) begin
        next_st.tx.data = st.sum + st.tx.data;
      end else begin
        next_st.tx.data = byte_at(st.idx + 4'h1, st.code, st.result,
                                  st.xlen, st.xdata);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tx_out   = st.tx;
  assign done_out = st.done;

endmodule

// *** core/sph_cmd_handler.sv ***
`timescale 1ns/1ps
module sph_cmd_handler (
  input  wire logic                   mclk_in,
  input  wire logic                   arst_n_in,
  input  sph_pkg::sph_byte_t          rx_in,
  output logic                        rx_ready_out,
  output sph_pkg::sph_byte_t          tx_out,
  input  wire logic                   tx_ready_in,
  output sph_pkg::sph_act_req_t       act_req_out,
  input  sph_pkg::sph_act_ans_t       act_ans_in,
  input  wire logic [5:0]             pay_rd_idx_in,
  output logic [7:0]                  pay_rd_byte_out,
  output logic                        busy_out
);
  import sph_pkg::*;

  typedef enum logic [2:0] {
    ST_HDR,
    ST_PAY,
    ST_SUM,
    ST_EXEC,
    ST_RESP
  } sph_phase_t;

  typedef struct packed {
    sph_phase_t   phase;
    logic [3:0]   hidx;
    logic [31:0]  pcnt;
    logic [7:0]   sum;
    logic [7:0]   ptype;
    logic [7:0]   code;
    logic [31:0]  len;
    logic [31:0]  addr;
    logic         ovf;
    sph_act_req_t req;
    logic         tx_start;
    logic [7:0]   result;
    logic [2:0]   xlen;
    logic [31:0]  xdata;
  } sph_rx_state_t;

  sph_rx_state_t st, next_st;

  // payload store; memory, so no reset
  logic [7:0] pay_mem [0:(1 << SPH_BUF_AW) - 1];
  logic [7:0] rd_byte;
  logic       tx_done;
  logic       take;

  // true for every code the device knows
  function automatic logic code_known(input logic [7:0] c);
    code_known = (c == SPH_FLASH_WRITE_CMD)
              || (c == SPH_OTP_WRITE_CMD)
              || (c == SPH_OTP_READ_CMD)
              || (c == SPH_DEBUG_AUTH_SET_CMD)
              || (c == SPH_DEBUG_AUTH_GET_CMD)
              || (c == SPH_DEBUG_AUTH_KEY_SET_CMD)
              || (c == SPH_SERIAL_BOOT_DISABLE_CMD)
              || (c == SPH_SERIAL_BOOT_QUERY_CMD)
              || (c == SPH_CHIP_SERIAL_READ_CMD)
              || (c == SPH_SERIAL_BOOT_AUTH_SET_CMD)
              || (c == SPH_SERIAL_BOOT_AUTH_GET_CMD)
              || (c == SPH_SERIAL_BOOT_KEY_SET_CMD);
  endfunction

  // error result for a finished request, ok when zero
  function automatic logic [7:0] check(input logic [7:0] s,
                                       input logic [7:0] got,
                                       input logic [7:0] t,
                                       input logic [7:0] c,
                                       input logic [31:0] n,
                                       input logic       o);
    if (s != got)                 check = SPH_RES_BAD_SUM;
    else if (t != SPH_TYPE_REQ)   check = SPH_RES_BAD_TYPE;
    else if (!code_known(c))      check = SPH_RES_BAD_CODE;
    else if (o)                   check = SPH_RES_BAD_LEN;
    else if (c == SPH_FLASH_WRITE_CMD && n < SPH_FLASH_ADDR_BYTES)
      check = SPH_RES_BAD_LEN;
    else                          check = SPH_RES_OK;
  endfunction

  assign take = rx_in.valid && rx_ready_out;

  // =====================================================
  // request parser and dispatcher
  always_comb begin
    next_st = st;
    next_st.req.start = 1'b0;
    next_st.tx_start  = 1'b0;
    case (st.phase)
      ST_HDR: begin
        if (take) begin
          next_st.sum  = st.sum + rx_in.data;
          next_st.hidx = st.hidx + 4'h1;
          if (st.hidx == SPH_POS_TYPE) begin
            next_st.ptype = rx_in.data;
          end else if (st.hidx == SPH_POS_CODE) begin
            next_st.code = rx_in.data;
          end else if (st.hidx >= SPH_POS_LEN) begin
            // little-endian length, low byte first
            next_st.len = {rx_in.data, st.len[31:8]};
          end
          // bytes 2 and 3 only enter the sum
          if (st.hidx == SPH_HDR_LAST) begin
            next_st.pcnt = SPH_WORD_RST;
            next_st.ovf  = 1'b0;
            next_st.addr = SPH_WORD_RST;
            next_st.phase = ({rx_in.data, st.len[31:8]} == SPH_WORD_RST)
                          ? ST_SUM : ST_PAY;
          end
        end
      end
      ST_PAY: begin
        if (take) begin
          next_st.sum  = st.sum + rx_in.data;
          next_st.pcnt = st.pcnt + 32'h1;
          if (st.pcnt < SPH_FLASH_ADDR_BYTES) begin
            next_st.addr = {rx_in.data, st.addr[31:8]};
          end
          if (st.pcnt >= SPH_BUF_BYTES) begin
            next_st.ovf = 1'b1;
          end
          if (st.pcnt + 32'h1 == st.len) begin
            next_st.phase = ST_SUM;
          end
        end
      end
      ST_SUM: begin
        if (take) begin
          next_st.result = check(st.sum, rx_in.data, st.ptype, st.code,
                                 st.len, st.ovf);
          next_st.xlen  = 3'h0;
          next_st.xdata = SPH_WORD_RST;
          if (check(st.sum, rx_in.data, st.ptype, st.code, st.len,
                    st.ovf) == SPH_RES_OK) begin
            next_st.req.start = 1'b1;
            next_st.req.code  = st.code;
            next_st.req.len   = st.len;
            next_st.req.addr  = st.addr;
            next_st.phase     = ST_EXEC;
          end else begin
            // nothing is started on a bad request
            next_st.tx_start = 1'b1;
            next_st.phase    = ST_RESP;
          end
        end
      end
      ST_EXEC: begin
        // the answer waits for the action to finish
        if (act_ans_in.done) begin
          next_st.result   = act_ans_in.result;
          next_st.xlen     = (st.code == SPH_FLASH_WRITE_CMD)
                           ? 3'h0 : act_ans_in.extra_len;
          next_st.xdata    = act_ans_in.extra_data;
          next_st.tx_start = 1'b1;
          next_st.phase    = ST_RESP;
        end
      end
      ST_RESP: begin
        if (tx_done) begin
          next_st.phase = ST_HDR;
          next_st.hidx  = SPH_IDX_RST;
          next_st.sum   = SPH_BYTE_RST;
        end
      end
      default: begin
        next_st.phase = ST_HDR;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================
  // payload buffer; bytes beyond its depth only count
  always_ff @(posedge mclk_in) begin
    if (st.phase == ST_PAY && take && st.pcnt < SPH_BUF_BYTES) begin
      pay_mem[st.pcnt[SPH_BUF_AW-1:0]] <= rx_in.data;
    end
  end

  // registered read port for the action engine
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_byte <= SPH_BYTE_RST;
    end else begin
      rd_byte <= pay_mem[pay_rd_idx_in];
    end
  end

  // =====================================================
  // response sender
  sph_resp_tx u_tx (
    .mclk_in       (mclk_in),
    .arst_n_in     (arst_n_in),
    .start_in      (st.tx_start),
    .code_in       (st.code),
    .result_in     (st.result),
    .extra_len_in  (st.xlen),
    .extra_data_in (st.xdata),
    .tx_ready_in   (tx_ready_in),
    .tx_out        (tx_out),
    .done_out      (tx_done)
  );

  // the link is held off while an action or answer is pending
  assign rx_ready_out = (st.phase == ST_HDR) || (st.phase == ST_PAY)
                     || (st.phase == ST_SUM);
  assign act_req_out     = st.req;
  assign pay_rd_byte_out = rd_byte;
  assign busy_out        = (st.phase == ST_EXEC) || (st.phase == ST_RESP);

endmodule

// *** test/sph_cmd_handler_chk.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checker for the command handler
module sph_cmd_handler_chk (
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  input  wire logic             rx_ready_out,
  input  sph_pkg::sph_byte_t    tx_out,
  input  wire logic             tx_ready_in,
  input  sph_pkg::sph_act_req_t act_req_out,
  input  sph_pkg::sph_act_ans_t act_ans_in,
  input  wire logic             busy_out
);
  import sph_pkg::*;
  logic wait_q;
  // action window: opened by start, closed by its done pulse
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) wait_q <= 1'b0;
    else if (act_req_out.start) wait_q <= 1'b1;
    else if (act_ans_in.done) wait_q <= 1'b0;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========================================================
  // properties
  property p_tx_hold;
    tx_out.valid && !tx_ready_in |=> tx_out.valid && $stable(tx_out.data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte dropped before taken");
  property p_start_pulse;
    act_req_out.start |=> !act_req_out.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_start_quiet;
    act_req_out.start |-> busy_out && !rx_ready_out && !tx_out.valid;
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("start while link not parked");
  property p_resp_after_done;
    wait_q && act_ans_in.done |-> ##2 tx_out.valid
      && tx_out.data == SPH_TYPE_RESP;
  endproperty
  a_resp_after_done: assert property (p_resp_after_done)
    else $error("response head missing after done");
  property p_one_action;
    wait_q |-> !act_req_out.start;
  endproperty
  a_one_action: assert property (p_one_action)
    else $error("second action in one request");
  property p_code_known;
    act_req_out.start |-> act_req_out.code inside {[8'h11:8'h18],
      [8'h21:8'h24]};
  endproperty
  a_code_known: assert property (p_code_known)
    else $error("action started on unknown code");
  property p_flash_len;
    act_req_out.start && act_req_out.code == SPH_FLASH_WRITE_CMD
      |-> act_req_out.len >= SPH_FLASH_ADDR_BYTES;
  endproperty
  a_flash_len: assert property (p_flash_len)
    else $error("flash write without address");
  property p_tx_busy;
    tx_out.valid |-> busy_out && !rx_ready_out && !wait_q;
  endproperty
  a_tx_busy: assert property (p_tx_busy)
    else $error("response byte outside send phase");
endmodule

// *** test/sph_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// host tool: streams queued request bytes, collects the answer
module sph_host_model (
  input  wire logic          mclk_in,
  input  wire logic          arst_n_in,
  output sph_pkg::sph_byte_t rx_out,
  input  wire logic          rx_ready_in,
  input  sph_pkg::sph_byte_t tx_in,
  output logic               tx_ready_out
);
  import sph_pkg::*;
  logic [7:0] req_q[$];
  logic [7:0] resp_q[$];
  logic       sent = 1'b0;
  initial rx_out = '0;
  initial tx_ready_out = 1'b0;
  // handshakes are judged on the rising edge only
  always @(posedge mclk_in) begin
    if (arst_n_in && rx_out.valid && rx_ready_in) sent = 1'b1;
    if (tx_in.valid && tx_ready_out) resp_q.push_back(tx_in.data);
  end
  // bytes go out in packet order; idle data toggles so stale is visible
  always @(negedge mclk_in) begin
    if (sent) void'(req_q.pop_front());
    sent = 1'b0;
    if (req_q.size() > 0) rx_out = {1'b1, req_q[0]};
    else rx_out = {1'b0, ~rx_out.data};
    tx_ready_out = ($urandom_range(0, 3) != 0);
  end
endmodule

// *** test/sph_cmd_handler_tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the command handler
module sph_cmd_handler_tb;
  import sph_pkg::*;
  logic         mclk_in = 1'b0;
  logic         arst_n_in = 1'b0;
  sph_byte_t    rx_in;
  sph_byte_t    tx_out;
  logic         rx_ready_out;
  logic         tx_ready_in;
  logic         busy_out;
  sph_act_req_t act_req_out;
  sph_act_ans_t act_ans_in = '0;
  logic [5:0]   pay_rd_idx_in = 6'h00;
  logic [7:0]   pay_rd_byte_out;
  logic [7:0]   pay[$];
  logic [7:0]   cur_c;
  logic [7:0]   eres;
  logic [7:0]   rd_idx = 8'h00;
  logic [2:0]   xl;
  logic [2:0]   xa;
  logic [31:0]  xd;
  logic         rd_chk = 1'b0;
  int           failures = 0;
  int           checked = 0;
  int           starts = 0;
  int           dly = 0;
  int           cur_n;

  always #50 mclk_in = ~mclk_in;

  sph_cmd_handler i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .rx_in(rx_in), .rx_ready_out(rx_ready_out), .tx_out(tx_out),
    .tx_ready_in(tx_ready_in), .act_req_out(act_req_out),
    .act_ans_in(act_ans_in), .pay_rd_idx_in(pay_rd_idx_in),
    .pay_rd_byte_out(pay_rd_byte_out), .busy_out(busy_out));
  sph_host_model i_host (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .rx_out(rx_in), .rx_ready_in(rx_ready_out), .tx_in(tx_out),
    .tx_ready_out(tx_ready_in));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [7:0] sum8(input logic [7:0] q[$]);
    logic [7:0] s = 8'h00;
    foreach (q[i]) s += q[i];
    return s;
  endfunction

  // stand-in setup engine: slow random answer, probes payload meanwhile
  always @(negedge mclk_in) begin
    act_ans_in = '0;
    if (act_req_out.start === 1'b1) begin
      starts++;
      check(act_req_out.code, cur_c);
      check(act_req_out.len, cur_n);
      if (cur_c == SPH_FLASH_WRITE_CMD)
        check(act_req_out.addr, {pay[3], pay[2], pay[1], pay[0]});
      dly = $urandom_range(1, 5);
      rd_chk = 1'b0;
    end else if (dly > 0) begin
      if (rd_chk) check(pay_rd_byte_out, pay[rd_idx]);
      rd_chk = (cur_n > 0);
      if (rd_chk) rd_idx = 8'($urandom_range(0, cur_n - 1));
      pay_rd_idx_in = rd_idx[5:0];
      dly--;
      if (dly == 0) act_ans_in = '{1'b1, eres, xa, xd};
    end
  end

  // one request, then the whole answer compared byte by byte
  task automatic run_pkt(input logic [7:0] t, input logic [7:0] c,
      input int n, input logic bad, input logic [7:0] ecode);
    logic [7:0]  b[$];
    logic [7:0]  r[$];
    logic [31:0] nn;
    int          k;
    int          st0;
    nn = n;
    pay = {};
    for (k = 0; k < n; k++) pay.push_back(8'($urandom));
    cur_c = c;
    cur_n = n;
    // engine may offer extra bytes on any code; flash answers must drop them
    xa = (ecode == 8'h00) ? 3'($urandom_range(0, 4)) : 3'h0;
    xl = (c == SPH_FLASH_WRITE_CMD) ? 3'h0 : xa;
    xd = $urandom;
    eres = (ecode == 8'h00) ? 8'($urandom) : ecode;
    b = {t, c, 8'($urandom), 8'($urandom), nn[7:0], nn[15:8], nn[23:16],
      nn[31:24]};
    b = {b, pay};
    b.push_back(sum8(b) + {7'h00, bad});
    r = {SPH_TYPE_RESP, c, 8'h00, 8'h00, 8'(xl) + 8'h01, 8'h00, 8'h00,
      8'h00, eres};
    for (k = 0; k < xl; k++) r.push_back(xd[8*k +: 8]);
    r.push_back(sum8(r));
    st0 = starts;
    i_host.resp_q = {};
    i_host.req_q = b;
    for (k = 0; k < 4000 && i_host.resp_q.size() < r.size(); k++)
      @(negedge mclk_in);
    if (k == 4000) begin
      failures++;
      stop_test();
    end
    repeat (3) @(negedge mclk_in);
    check(i_host.resp_q.size(), r.size());
    for (k = 0; k < r.size(); k++) check(i_host.resp_q[k], r[k]);
    check(starts - st0, (ecode == 8'h00));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] codes[12] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
      8'h17, 8'h18, 8'h21, 8'h22, 8'h23, 8'h24};
    void'($urandom(32'h353b));
    repeat (5) @(negedge mclk_in);
    arst_n_in = 1'b1;
    @(negedge mclk_in);
    for (int i = 0; i < 12; i++)
      run_pkt(SPH_TYPE_REQ, codes[i], (i == 0 ? 4 : 0) +
        $urandom_range(0, 8), 1'b0, SPH_RES_OK);
    run_pkt(SPH_TYPE_REQ, SPH_FLASH_WRITE_CMD, 64, 1'b0, SPH_RES_OK);
    run_pkt(SPH_TYPE_REQ, SPH_OTP_READ_CMD, 65, 1'b0, SPH_RES_BAD_LEN);
    run_pkt(SPH_TYPE_REQ, SPH_FLASH_WRITE_CMD, 3, 1'b0, SPH_RES_BAD_LEN);
    run_pkt(SPH_TYPE_REQ, 8'h14, 2, 1'b1, SPH_RES_BAD_SUM);
    run_pkt(SPH_TYPE_RESP, 8'h14, 2, 1'b0, SPH_RES_BAD_TYPE);
    run_pkt(SPH_TYPE_REQ, 8'h19, 0, 1'b0, SPH_RES_BAD_CODE);
    run_pkt(8'h51, 8'h30, 1, 1'b1, SPH_RES_BAD_SUM);
    // mixed traffic, back to back
    for (int i = 0; i < 20; i++)
      run_pkt(SPH_TYPE_REQ, codes[$urandom_range(0, 11)],
        $urandom_range(4, 12), 1'b0, SPH_RES_OK);
    stop_test();
  end
endmodule

bind sph_cmd_handler sph_cmd_handler_chk i_chk (.mclk_in(mclk_in),
  .arst_n_in(arst_n_in), .rx_ready_out(rx_ready_out), .tx_out(tx_out),
  .tx_ready_in(tx_ready_in), .act_req_out(act_req_out),
  .act_ans_in(act_ans_in), .busy_out(busy_out));
